/* src/low_freq_osc_control.sv */
`timescale 1ns/1ps
// Behaviour
// - Divider codes 00,01,10,11 divide 8,4,2,1
// - Enable bit 7 runs or stops oscillator
// - Ready bit 6 reads one once stable
// - Ready clears only on reset, divider change
// - Trim bits 5:2; zero fastest, ones slowest
// - Timer2 captures falling, timer3 rising edges
// - Capture copies timer count into reload pair
// - Source nominally 80 kHz before divider
module low_freq_osc_control
   import lfo_pkg::*;
#(
   parameter int STAB_COUNT = STAB_EDGES
) (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        CE,
   input  wire logic [7:0]  SFR_ADDR,
   input  wire logic [7:0]  SFR_WDATA,
   input  wire logic        SFR_WR,
   input  wire logic        SFR_RD,
   output logic      [7:0]  SFR_RDATA,
   input  wire logic        LF_OSC_RAW,
   input  wire logic [3:0]  FACTORY_TRIM,
   output logic             LF_ENABLE,
   output logic      [3:0]  LF_TRIM,
   output logic             LF_DIV_OUT,
   input  wire logic        TMR2_CAP_MODE,
   input  wire logic [15:0] TMR2_COUNT,
   output logic      [15:0] TMR2_RELOAD,
   output logic             TMR2_CAPTURED,
   input  wire logic        TMR3_CAP_MODE,
   input  wire logic [15:0] TMR3_COUNT,
   output logic      [15:0] TMR3_RELOAD,
   output logic             TMR3_CAPTURED
);
   if (STAB_COUNT < 1 || STAB_COUNT > 255) begin : g_bad_param
      $error("STAB_COUNT must lie in 1..255");
   end

   logic             wr_hit;
   logic             rd_hit;
   logic             div_change;
   logic [1:0]       div_sel;
   logic [1:0]       next_div_sel;
   logic             next_enable;
   logic [3:0]       next_trim;
   logic             raw_s1;
   logic             raw_s2;
   logic             raw_prev;
   logic             raw_rise;
   logic [2:0]       div_cnt;
   logic [2:0]       next_div_cnt;
   logic             next_div_out;
   rdy_state_t       rdy_state;
   rdy_state_t       next_rdy_state;
   logic [7:0]       edge_cnt;
   logic [7:0]       next_edge_cnt;
   logic [10:0]      gap_cnt;
   logic [10:0]      next_gap_cnt;
   logic             ready;
   logic [7:0]       next_rdata;

   assign wr_hit     = SFR_WR && (SFR_ADDR == LF_CTRL_ADDR);
   assign rd_hit     = SFR_RD && (SFR_ADDR == LF_CTRL_ADDR);
   assign div_change = wr_hit && (SFR_WDATA[DIV_LSB +: DIV_W] != div_sel);
   assign ready      = (rdy_state == RDY_DONE);

   // Control register
   always_comb begin
      next_enable  = LF_ENABLE;
      next_trim    = LF_TRIM;
      next_div_sel = div_sel;
      if (wr_hit) begin
         next_enable  = SFR_WDATA[EN_BIT];
         // Trim is passed straight on; retuning while running is not blocked
         next_trim    = SFR_WDATA[TRIM_LSB +: TRIM_W];
         next_div_sel = SFR_WDATA[DIV_LSB +: DIV_W];
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         LF_ENABLE <= EN_RESET;
         LF_TRIM   <= FACTORY_TRIM;
         div_sel   <= DIV_RESET;
      end else if (CE) begin
         LF_ENABLE <= next_enable;
         LF_TRIM   <= next_trim;
         div_sel   <= next_div_sel;
      end
   end

   // Oscillator input is asynchronous to CLK
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         raw_s1   <= 1'b0;
         raw_s2   <= 1'b0;
         raw_prev <= 1'b0;
      end else if (CE) begin
         raw_s1   <= LF_OSC_RAW;
         raw_s2   <= raw_s1;
         raw_prev <= raw_s2;
      end
   end

   assign raw_rise = raw_s2 && !raw_prev;

   // Divider on the synchronised source
   always_comb begin
      next_div_cnt = div_cnt;
      if (!LF_ENABLE) begin
         next_div_cnt = 3'h0;
      end else if (raw_rise) begin
         next_div_cnt = div_cnt + 3'h1;
      end
      next_div_out = LF_ENABLE && div_tap(next_div_cnt, raw_s2, div_sel);
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         div_cnt    <= 3'h0;
         LF_DIV_OUT <= 1'b0;
      end else if (CE) begin
         div_cnt    <= next_div_cnt;
         LF_DIV_OUT <= next_div_out;
      end
   end

   // Stability: a run of edges each within twice the nominal period
   always_comb begin
      next_rdy_state = rdy_state;
      next_edge_cnt  = edge_cnt;
      next_gap_cnt   = gap_cnt;
      if (gap_cnt != 11'h7ff) begin
         next_gap_cnt = gap_cnt + 11'h001;
      end
      case (rdy_state)
         RDY_IDLE: begin
            next_edge_cnt = 8'h00;
            next_gap_cnt  = 11'h000;
            if (LF_ENABLE) begin
               next_rdy_state = RDY_SETTLE;
            end
         end
         RDY_SETTLE: begin
            if (!LF_ENABLE || div_change) begin
               next_rdy_state = RDY_IDLE;
            end else if (raw_rise) begin
               next_gap_cnt = 11'h000;
               if (gap_cnt > 11'(MAX_GAP_CYC)) begin
                  next_edge_cnt = 8'h00;
               end else if (edge_cnt == 8'(STAB_COUNT - 1)) begin
                  next_rdy_state = RDY_DONE;
               end else begin
                  next_edge_cnt = edge_cnt + 8'h01;
               end
            end
         end
         RDY_DONE: begin
            // Disabling keeps the flag; only a new divider clears it
            if (div_change) begin
               next_rdy_state = RDY_IDLE;
            end
         end
         default: begin
            next_rdy_state = RDY_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rdy_state <= RDY_IDLE;
         edge_cnt  <= 8'h00;
         gap_cnt   <= 11'h000;
      end else if (CE) begin
         rdy_state <= next_rdy_state;
         edge_cnt  <= next_edge_cnt;
         gap_cnt   <= next_gap_cnt;
      end
   end

   // Read port
   always_comb begin
      next_rdata = 8'h00;
      if (rd_hit) begin
         next_rdata = {LF_ENABLE, ready, LF_TRIM, div_sel};
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         SFR_RDATA <= 8'h00;
      end else if (CE) begin
         SFR_RDATA <= next_rdata;
      end
   end

   lf_capture #(
      .ON_RISE (1'b0)
   ) u_cap_t2 (
      .clk      (CLK),
      .rst      (SYS_RST),
      .ce       (CE),
      .osc_div  (LF_DIV_OUT),
      .cap_mode (TMR2_CAP_MODE),
      .count    (TMR2_COUNT),
      .reload   (TMR2_RELOAD),
      .captured (TMR2_CAPTURED)
   );

   lf_capture #(
      .ON_RISE (1'b1)
   ) u_cap_t3 (
      .clk      (CLK),
      .rst      (SYS_RST),
      .ce       (CE),
      .osc_div  (LF_DIV_OUT),
      .cap_mode (TMR3_CAP_MODE),
      .count    (TMR3_COUNT),
      .reload   (TMR3_RELOAD),
      .captured (TMR3_CAPTURED)
   );

   // Helper: source rises between rises of the divided output
   logic [3:0] rise_tally;
   logic       ratio_ok;
   always_ff @(posedge CLK) begin
      if (SYS_RST || wr_hit || !LF_ENABLE || !CE) begin
         rise_tally <= 4'h0;
         ratio_ok   <= 1'b0;
      end else if (LF_DIV_OUT && !$past(LF_DIV_OUT)) begin
         rise_tally <= 4'h0;
         ratio_ok   <= 1'b1;
      end else if (raw_rise) begin
         rise_tally <= rise_tally + 4'h1;
      end
   end

   // Building blocks: a taken control write, and a divider retune while ready
   sequence s_ctrl_write;
      CE && wr_hit;
   endsequence

   sequence s_div_retune;
      CE && ready && div_change;
   endsequence

   chk_div_ratio: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && ratio_ok && $rose(LF_DIV_OUT)) |-> rise_tally == divisor(div_sel))
      else $error("divided output ratio wrong");
   chk_enable_write: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_ctrl_write |=> LF_ENABLE == $past(SFR_WDATA[EN_BIT]))
      else $error("enable bit not taken from write");
   chk_stopped_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && !LF_ENABLE) |=> !LF_DIV_OUT)
      else $error("divided output toggles while stopped");
   chk_ready_read: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && rd_hit) |=> SFR_RDATA[RDY_BIT] == $past(ready))
      else $error("read ready bit differs from flag");
   chk_ready_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
      (ready && !div_change) |=> ready)
      else $error("ready dropped without divider change");
   chk_ready_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_div_retune |=> !ready)
      else $error("ready kept after divider change");
   chk_trim_write: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_ctrl_write |=> LF_TRIM == $past(SFR_WDATA[TRIM_LSB +: TRIM_W]))
      else $error("trim output not taken from write");
   chk_settle_count: assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(ready) |-> $past(edge_cnt) == 8'(STAB_COUNT - 1) && $past(raw_rise))
      else $error("ready set before settle run complete");
endmodule

/* src/lfo_pkg.sv */
package lfo_pkg;
   localparam logic [7:0] LF_CTRL_ADDR   = 8'h86;
   localparam int         EN_BIT         = 7;
   localparam int         RDY_BIT        = 6;
   localparam int         TRIM_LSB       = 2;
   localparam int         TRIM_W         = 4;
   localparam int         DIV_LSB        = 0;
   localparam int         DIV_W          = 2;
   localparam logic       EN_RESET       = 1'b0;
   localparam logic [1:0] DIV_RESET      = 2'h0;
   localparam logic [1:0] DIV_BY_8       = 2'h0;
   localparam logic [1:0] DIV_BY_4       = 2'h1;
   localparam logic [1:0] DIV_BY_2       = 2'h2;
   localparam logic [1:0] DIV_BY_1       = 2'h3;
   localparam int         CLK_HZ         = 40000000;
   localparam int         LF_NOMINAL_HZ  = 80000;
   localparam int         LF_PERIOD_CYC  = CLK_HZ / LF_NOMINAL_HZ;
   localparam int         MAX_GAP_CYC    = 2 * LF_PERIOD_CYC;
   localparam int         STAB_EDGES     = 16;

   typedef enum logic [1:0] {RDY_IDLE, RDY_SETTLE, RDY_DONE} rdy_state_t;

   function automatic logic [3:0] divisor(input logic [1:0] sel);
      case (sel)
         DIV_BY_8: divisor = 4'h8;
         DIV_BY_4: divisor = 4'h4;
         DIV_BY_2: divisor = 4'h2;
         default:  divisor = 4'h1;
      endcase
   endfunction

   function automatic logic div_tap(input logic [2:0] cnt, input logic raw,
                                    input logic [1:0] sel);
      case (sel)
         DIV_BY_8: div_tap = cnt[2];
         DIV_BY_4: div_tap = cnt[1];
         DIV_BY_2: div_tap = cnt[0];
         default:  div_tap = raw;
      endcase
   endfunction
endpackage

/* src/lf_capture.sv */
`timescale 1ns/1ps
module lf_capture
   import lfo_pkg::*;
#(
   parameter bit ON_RISE = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        osc_div,
   input  wire logic        cap_mode,
   input  wire logic [15:0] count,
   output logic      [15:0] reload,
   output logic             captured
);
   logic        prev;
   logic        edge_seen;
   logic        next_prev;
   logic [15:0] next_reload;
   logic        next_captured;

   // Input is already a registered level on CLK, so one capture per edge
   assign edge_seen = ON_RISE ? (osc_div & ~prev) : (~osc_div & prev);

   always_comb begin
      next_prev     = osc_div;
      next_reload   = reload;
      next_captured = 1'b0;
      if (cap_mode && edge_seen) begin
         next_reload   = count;
         next_captured = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev     <= 1'b0;
         reload   <= 16'h0000;
         captured <= 1'b0;
      end else if (ce) begin
         prev     <= next_prev;
         reload   <= next_reload;
         captured <= next_captured;
      end
   end

   chk_capture_edge: assert property (@(posedge clk) disable iff (rst)
      (ce && cap_mode && edge_seen) |=> captured)
      else $error("capture missed on oscillator edge");
   chk_capture_copy: assert property (@(posedge clk) disable iff (rst)
      (ce && $rose(captured)) |-> reload == $past(count))
      else $error("reload does not hold captured count");
   chk_single_capture: assert property (@(posedge clk) disable iff (rst)
      (ce && captured && $past(ce)) |=> !captured)
      else $error("one oscillator edge captured twice");
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import lfo_pkg::*;
   localparam logic [3:0] FTRIM = 4'ha;
   localparam int         HALF  = LF_PERIOD_CYC / 2;
   logic        CLK = 1'b0;
   logic        SYS_RST = 1'b1;
   logic        CE = 1'b1;
   logic [7:0]  SFR_ADDR = 8'h00;
   logic [7:0]  SFR_WDATA = 8'h00;
   logic        SFR_WR = 1'b0;
   logic        SFR_RD = 1'b0;
   logic [7:0]  SFR_RDATA;
   logic        LF_OSC_RAW = 1'b0;
   logic        LF_ENABLE;
   logic [3:0]  LF_TRIM;
   logic        LF_DIV_OUT;
   logic        TMR2_CAP_MODE = 1'b0;
   logic        TMR3_CAP_MODE = 1'b0;
   logic [15:0] TMR_COUNT = 16'h0000;
   logic [15:0] TMR2_RELOAD;
   logic [15:0] TMR3_RELOAD;
   logic        TMR2_CAPTURED;
   logic        TMR3_CAPTURED;
   int          half_cnt = 0;
   int          n_fail = 0;
   int          checked = 0;
   int          cycles = 0;

   low_freq_osc_control #(.STAB_COUNT(2)) i_low_freq_osc_control (
      .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .SFR_ADDR(SFR_ADDR),
      .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
      .LF_OSC_RAW(LF_OSC_RAW), .FACTORY_TRIM(FTRIM), .LF_ENABLE(LF_ENABLE),
      .LF_TRIM(LF_TRIM), .LF_DIV_OUT(LF_DIV_OUT), .TMR2_CAP_MODE(TMR2_CAP_MODE),
      .TMR2_COUNT(TMR_COUNT), .TMR2_RELOAD(TMR2_RELOAD), .TMR2_CAPTURED(TMR2_CAPTURED),
      .TMR3_CAP_MODE(TMR3_CAP_MODE), .TMR3_COUNT(TMR_COUNT), .TMR3_RELOAD(TMR3_RELOAD),
      .TMR3_CAPTURED(TMR3_CAPTURED));

   always #12.5 CLK = ~CLK;

   // Stand-in oscillator: stopped source holds its level
   always @(posedge CLK) begin
      cycles++;
      TMR_COUNT <= TMR_COUNT + 16'h0001;
      if (LF_ENABLE === 1'b1) begin
         if (half_cnt == HALF - 1) begin
            half_cnt <= 0;
            LF_OSC_RAW <= ~LF_OSC_RAW;
         end else begin
            half_cnt <= half_cnt + 1;
         end
      end
      if (cycles == 80000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      SFR_ADDR <= a;
      SFR_WDATA <= d;
      SFR_WR <= 1'b1;
      @(posedge CLK);
      SFR_WR <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLK);
      SFR_ADDR <= a;
      SFR_RD <= 1'b1;
      @(posedge CLK);
      SFR_RD <= 1'b0;
      #1 d = SFR_RDATA;
   endtask

   task automatic div_rise(output int n);
      logic prev;
      n = 0;
      prev = LF_DIV_OUT;
      do begin
         @(posedge CLK);
         #1;
         n++;
         if (LF_DIV_OUT === 1'b1 && prev === 1'b0) return;
         prev = LF_DIV_OUT;
      end while (n < 5000);
   endtask

   task automatic wait_cap(input logic t3, output logic [15:0] r);
      int n;
      n = 0;
      do begin
         @(posedge CLK);
         #1;
         n++;
      end while ((t3 ? TMR3_CAPTURED : TMR2_CAPTURED) !== 1'b1 && n < 2000);
      r = t3 ? TMR3_RELOAD : TMR2_RELOAD;
      // Count was sampled at the capturing edge, bench counter has moved on by one
      chk_val(r, TMR_COUNT - 16'h0001);
      chk_bit(LF_DIV_OUT, t3);
      @(posedge CLK);
      #1;
      chk_bit(t3 ? TMR3_CAPTURED : TMR2_CAPTURED, 1'b0);
   endtask

   task automatic t_reset_and_refuse();
      logic [7:0] d;
      rd(LF_CTRL_ADDR, d);
      chk_val({8'h00, d}, {8'h00, 2'b00, FTRIM, 2'b00});
      chk_bit(LF_ENABLE, 1'b0);
      wr(8'h87, 8'hff);
      chk_bit(LF_ENABLE, 1'b0);
      rd(8'h87, d);
      chk_val({8'h00, d}, 16'h0000);
      @(posedge CLK);
      CE <= 1'b0;
      wr(LF_CTRL_ADDR, 8'h80);
      chk_bit(LF_ENABLE, 1'b0);
      @(posedge CLK);
      CE <= 1'b1;
   endtask

   task automatic t_trim();
      logic [7:0] d;
      wr(LF_CTRL_ADDR, 8'h00);
      chk_val({12'h000, LF_TRIM}, 16'h0000);
      wr(LF_CTRL_ADDR, 8'h3e);
      chk_val({12'h000, LF_TRIM}, 16'h000f);
      rd(LF_CTRL_ADDR, d);
      chk_val({8'h00, d}, 16'h003e);
   endtask

   task automatic t_ready();
      logic [7:0] d;
      int         k;
      wr(LF_CTRL_ADDR, 8'h83);
      chk_bit(LF_ENABLE, 1'b1);
      rd(LF_CTRL_ADDR, d);
      chk_bit(d[RDY_BIT], 1'b0);
      k = 0;
      do begin
         rd(LF_CTRL_ADDR, d);
         k++;
      end while (d[RDY_BIT] !== 1'b1 && k < 1500);
      chk_val({8'h00, d}, 16'h00c3);
      // Stopping the source must not lose the ready state
      wr(LF_CTRL_ADDR, 8'h03);
      chk_bit(LF_ENABLE, 1'b0);
      rd(LF_CTRL_ADDR, d);
      chk_bit(d[RDY_BIT], 1'b1);
      wr(LF_CTRL_ADDR, 8'h02);
      rd(LF_CTRL_ADDR, d);
      chk_bit(d[RDY_BIT], 1'b0);
      wr(LF_CTRL_ADDR, 8'h42);
      rd(LF_CTRL_ADDR, d);
      chk_val({8'h00, d}, 16'h0002);
      chk_bit(LF_DIV_OUT, 1'b0);
   endtask

   task automatic t_divider();
      int         divs[4] = '{8, 4, 2, 1};
      logic [7:0] d;
      int         n;
      for (int i = 0; i < 4; i++) begin
         wr(LF_CTRL_ADDR, 8'h80 | 8'(i));
         rd(LF_CTRL_ADDR, d);
         chk_bit(d[RDY_BIT], 1'b0);
         div_rise(n);
         div_rise(n);
         div_rise(n);
         chk_val(16'(n), 16'(LF_PERIOD_CYC * divs[i]));
      end
   endtask

   task automatic t_capture();
      logic [15:0] r1;
      logic [15:0] r2;
      int          k;
      @(posedge CLK);
      TMR2_CAP_MODE <= 1'b1;
      TMR3_CAP_MODE <= 1'b1;
      wait_cap(1'b0, r1);
      wait_cap(1'b0, r2);
      chk_val(r2 - r1, 16'(LF_PERIOD_CYC));
      wait_cap(1'b1, r1);
      wait_cap(1'b1, r2);
      chk_val(r2 - r1, 16'(LF_PERIOD_CYC));
      @(posedge CLK);
      TMR2_CAP_MODE <= 1'b0;
      TMR3_CAP_MODE <= 1'b0;
      k = 0;
      repeat (2 * LF_PERIOD_CYC) begin
         @(posedge CLK);
         #1;
         if (TMR2_CAPTURED !== 1'b0 || TMR3_CAPTURED !== 1'b0) k++;
      end
      chk_val(16'(k), 16'h0000);
   endtask

   task automatic t_reset_again();
      logic [7:0] d;
      @(posedge CLK);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'b0;
      rd(LF_CTRL_ADDR, d);
      chk_val({8'h00, d}, {8'h00, 2'b00, FTRIM, 2'b00});
      chk_val(TMR3_RELOAD, 16'h0000);
      chk_val(TMR2_RELOAD, 16'h0000);
      chk_bit(LF_DIV_OUT, 1'b0);
   endtask

   initial begin
      repeat (8) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_reset_and_refuse();
      t_trim();
      t_ready();
      t_divider();
      t_capture();
      t_reset_again();
      print_verdict();
   end
endmodule
